// File: hdl/nvm_regs_defs.svh
// offsets, field positions and reset values of the flash command/irq registers
// assumes: included by bare name; definitions only
`ifndef NVM_REGS_DEFS_SVH
`define NVM_REGS_DEFS_SVH

// byte offsets on the register bus
`define NVM_OFS_CMD        8'h00
`define NVM_OFS_IRQ_EN     8'h04
`define NVM_OFS_STATUS     8'h08

// command register fields
`define NVM_CMD_OP_HI      31
`define NVM_CMD_OP_LO      24
`define NVM_CMD_PAGE_HI    19
`define NVM_CMD_PAGE_LO    0
`define NVM_CMD_WMASK      32'hff0f_ffff
`define NVM_CMD_OP_LANE    3

// per-bank half layout, bank one sits in the upper half
`define NVM_HALF_W         16
`define NVM_ILLEGAL_POS    15
`define NVM_CODE_HI        9
`define NVM_CODE_LO        8
`define NVM_EVT_HI         7
`define NVM_EVT_LO         1
`define NVM_BUSY_POS       0
`define NVM_IRQ_WMASK      32'h80fe_80fe

// reset values
`define NVM_RST_CMD        32'h0000_0000
`define NVM_RST_IRQ_EN     32'h0000_0000
`define NVM_RST_FLAGS      8'h00

`endif

// File: hdl/nvm_regs_pkg.sv
// types and field helpers shared by the flash register bank modules
// assumes: nvm_regs_defs.svh is on the include path
`include "nvm_regs_defs.svh"

package nvm_regs_pkg;

    typedef enum logic [1:0] {SEL_NONE, SEL_CMD, SEL_IRQ_EN, SEL_STATUS} reg_sel_t;

    // event order: 7 illegal, 6 done, 5 ecc2, 4 ecc1, 3 wear, 2 erase, 1 burn, 0 guard
    typedef logic [7:0] evt_t;

    // spread one bank's events onto its register half
    function automatic logic [15:0] pack_half(input evt_t ev);
        logic [15:0] h;
        h = '0;
        h[`NVM_ILLEGAL_POS] = ev[7];
        h[`NVM_EVT_HI:`NVM_EVT_LO] = ev[6:0];
        return h;
    endfunction : pack_half

    function automatic evt_t unpack_half(input logic [15:0] h);
        return {h[`NVM_ILLEGAL_POS], h[`NVM_EVT_HI:`NVM_EVT_LO]};
    endfunction : unpack_half

    // byte enables to a bit mask
    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction : lane_mask

endpackage : nvm_regs_pkg

// File: hdl/nvm_bus_if.sv
// decoded register access between the bus front end and the register logic
// assumes: one clock; strobes last one cycle
`timescale 1ns/1ns
`default_nettype none

interface nvm_bus_if;
    import nvm_regs_pkg::*;
    logic        wr_stb;
    logic        rd_stb;
    reg_sel_t    sel;
    logic [31:0] wdata;
    logic [3:0]  be;
    logic [31:0] rdata;

    modport dec   (output wr_stb, output rd_stb, output sel, output wdata, output be,
                   input rdata);
    modport regs  (input wr_stb, input rd_stb, input sel, input wdata, input be,
                   output rdata);
    modport flags (input wr_stb, input sel, input wdata, input be);
endinterface : nvm_bus_if

`default_nettype wire

// File: hdl/nvm_wb_front.sv
// classic wishbone slave front end: decode, one-wait-state ack, read data flop
// assumes: synchronous active-high reset; master holds the request until ack
`timescale 1ns/1ns
`default_nettype none

module nvm_wb_front
    import nvm_regs_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              cyc_i,
    input  wire logic              stb_i,
    input  wire logic              we_i,
    input  wire logic [ADDR_W-1:0] adr_i,
    input  wire logic [3:0]        sel_i,
    input  wire logic [31:0]       dat_i,
    output logic                   ack_o,
    output logic [31:0]            dat_o,
    nvm_bus_if.dec                 bus
);
    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
    } front_t;

    front_t st_ff;
    front_t nxt_st;
    logic   req;

    // ack high for one cycle masks the held request, keeping each request single
    assign req        = cyc_i & stb_i & ~st_ff.ack;
    assign bus.wr_stb = req & we_i;
    assign bus.rd_stb = req & ~we_i;
    assign bus.wdata  = dat_i;
    assign bus.be     = sel_i;
    assign ack_o      = st_ff.ack;
    assign dat_o      = st_ff.rdata;

    // word address decode; unmapped reads zero, writes dropped
    always_comb begin
        unique case ({adr_i[ADDR_W-1:2], 2'b00})
            ADDR_W'(`NVM_OFS_CMD):    bus.sel = SEL_CMD;
            ADDR_W'(`NVM_OFS_IRQ_EN): bus.sel = SEL_IRQ_EN;
            ADDR_W'(`NVM_OFS_STATUS): bus.sel = SEL_STATUS;
            default:                  bus.sel = SEL_NONE;
        endcase
    end

    always_comb begin
        nxt_st       = st_ff;
        nxt_st.ack   = req;
        nxt_st.rdata = (req & ~we_i) ? bus.rdata : st_ff.rdata;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // refuse at elaboration a map too small for three word registers
    if (ADDR_W < 4) begin : g_addr_w_check
        $error("nvm_wb_front: ADDR_W too small for the register map");
    end
endmodule : nvm_wb_front

`default_nettype wire

// File: hdl/nvm_event_flags.sv
// sticky per-bank event flags, write-one-to-clear, masked into one irq level
// assumes: event inputs are synchronous one-cycle pulses or levels
`timescale 1ns/1ns
`default_nettype none

module nvm_event_flags
    import nvm_regs_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire evt_t        evt_b0_i,
    input  wire evt_t        evt_b1_i,
    input  wire logic [31:0] mask_i,
    output logic [31:0]      flags_o,
    output logic             irq_o,
    nvm_bus_if.flags         bus
);
    typedef struct packed {
        evt_t flag_b0;
        evt_t flag_b1;
        logic irq;
    } flags_t;

    flags_t      st_ff;
    flags_t      nxt_st;
    logic [31:0] clr;

    assign flags_o = {pack_half(st_ff.flag_b1), pack_half(st_ff.flag_b0)};
    assign irq_o   = st_ff.irq;

    // a new event beats a clear landing in the same cycle
    always_comb begin
        nxt_st = st_ff;
        clr    = '0;
        if (bus.wr_stb && bus.sel == SEL_STATUS) begin
            clr = bus.wdata & lane_mask(bus.be);
        end
        nxt_st.flag_b0 = (st_ff.flag_b0 & ~unpack_half(clr[`NVM_HALF_W-1:0])) | evt_b0_i;
        nxt_st.flag_b1 = (st_ff.flag_b1 & ~unpack_half(clr[31:`NVM_HALF_W])) | evt_b1_i;
        nxt_st.irq = |({pack_half(nxt_st.flag_b1), pack_half(nxt_st.flag_b0)} & mask_i);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= '{flag_b0: `NVM_RST_FLAGS, flag_b1: `NVM_RST_FLAGS, irq: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule : nvm_event_flags

`default_nettype wire

// File: hdl/nvm_cmd_irq_regs.sv
// top of the flash command and interrupt-enable register bank
// assumes: classic wishbone master on clk_i; bank status inputs synchronous
`timescale 1ns/1ns
`default_nettype none

module nvm_cmd_irq_regs
    import nvm_regs_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              cyc_i,
    input  wire logic              stb_i,
    input  wire logic              we_i,
    input  wire logic [ADDR_W-1:0] adr_i,
    input  wire logic [3:0]        sel_i,
    input  wire logic [31:0]       dat_i,
    output logic                   ack_o,
    output logic [31:0]            dat_o,
    input  wire evt_t              evt_b0_i,
    input  wire evt_t              evt_b1_i,
    input  wire logic              busy_b0_i,
    input  wire logic              busy_b1_i,
    input  wire logic [1:0]        code_b0_i,
    input  wire logic [1:0]        code_b1_i,
    output logic [7:0]             cmd_code_o,
    output logic [19:0]            page_addr_o,
    output logic                   cmd_start_o,
    output logic                   irq_o
);
    typedef struct packed {
        logic [31:0] cmd;
        logic [31:0] irq_en;
        logic        start;
    } regs_t;

    regs_t       st_ff;
    regs_t       nxt_st;
    logic [31:0] flags;
    logic [31:0] status_rd;
    logic [31:0] bm;

    nvm_bus_if bus ();

    nvm_wb_front #(
        .ADDR_W (ADDR_W)
    ) u_front (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .cyc_i (cyc_i),
        .stb_i (stb_i),
        .we_i  (we_i),
        .adr_i (adr_i),
        .sel_i (sel_i),
        .dat_i (dat_i),
        .ack_o (ack_o),
        .dat_o (dat_o),
        .bus   (bus.dec)
    );

    nvm_event_flags u_flags (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .evt_b0_i (evt_b0_i),
        .evt_b1_i (evt_b1_i),
        .mask_i   (st_ff.irq_en),
        .flags_o  (flags),
        .irq_o    (irq_o),
        .bus      (bus.flags)
    );

    // outputs straight from the register flops
    assign cmd_code_o  = st_ff.cmd[`NVM_CMD_OP_HI:`NVM_CMD_OP_LO];
    assign page_addr_o = st_ff.cmd[`NVM_CMD_PAGE_HI:`NVM_CMD_PAGE_LO];
    assign cmd_start_o = st_ff.start;
    assign bm          = lane_mask(bus.be);

    // status word: sticky flags plus live busy and result code per bank
    always_comb begin
        status_rd = flags;
        status_rd[`NVM_BUSY_POS] = busy_b0_i;
        status_rd[`NVM_HALF_W + `NVM_BUSY_POS] = busy_b1_i;
        status_rd[`NVM_CODE_HI:`NVM_CODE_LO] = code_b0_i;
        status_rd[`NVM_HALF_W + `NVM_CODE_HI:`NVM_HALF_W + `NVM_CODE_LO] = code_b1_i;
    end

    // read mux; storage already holds zeros in reserved positions
    always_comb begin
        unique case (bus.sel)
            SEL_CMD:    bus.rdata = st_ff.cmd;
            SEL_IRQ_EN: bus.rdata = st_ff.irq_en;
            SEL_STATUS: bus.rdata = status_rd;
            SEL_NONE:   bus.rdata = 32'h0000_0000;
        endcase
    end

    // byte-lane writes; reserved bits are masked off so they never store
    always_comb begin
        nxt_st       = st_ff;
        nxt_st.start = 1'b0;
        if (bus.wr_stb && bus.sel == SEL_CMD) begin
            nxt_st.cmd = (st_ff.cmd & ~bm) | (bus.wdata & bm & `NVM_CMD_WMASK);
            // a new operation is launched when its code byte is written
            nxt_st.start = bus.be[`NVM_CMD_OP_LANE];
        end
        if (bus.wr_stb && bus.sel == SEL_IRQ_EN) begin
            // one enable per bank for each event, reserved slots dropped
            nxt_st.irq_en = (st_ff.irq_en & ~bm) | (bus.wdata & bm & `NVM_IRQ_WMASK);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= '{cmd: `NVM_RST_CMD, irq_en: `NVM_RST_IRQ_EN, start: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // refuse at elaboration a map too small for three word registers
    if (ADDR_W < 4) begin : g_addr_w_check
        $error("nvm_cmd_irq_regs: ADDR_W too small for the register map");
    end
endmodule : nvm_cmd_irq_regs

`default_nettype wire

// File: verification/nvm_regs_checker.sv
// concurrent checks on the flash command and irq-enable register bank
// assumes: bound to nvm_cmd_irq_regs; one clock, synchronous active-high reset
`timescale 1ns/1ns
`default_nettype none

module nvm_regs_checker
    import nvm_regs_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              cyc_i,
    input  wire logic              stb_i,
    input  wire logic              we_i,
    input  wire logic [ADDR_W-1:0] adr_i,
    input  wire logic [3:0]        sel_i,
    input  wire logic [31:0]       dat_i,
    input  wire logic              ack_o,
    input  wire logic [31:0]       dat_o,
    input  wire evt_t              evt_b0_i,
    input  wire evt_t              evt_b1_i,
    input  wire logic [7:0]        cmd_code_o,
    input  wire logic [19:0]       page_addr_o,
    input  wire logic              cmd_start_o,
    input  wire logic              irq_o
);
    logic take;
    logic wr;
    logic ev;
    logic cmd_hit;
    logic en_hit;
    logic launch;

    // a request is taken only while ack is low; events and writes are the only irq causes
    assign take    = cyc_i & stb_i & ~ack_o;
    assign wr      = cyc_i & stb_i & we_i;
    assign ev      = |{evt_b0_i, evt_b1_i};
    assign cmd_hit = adr_i[ADDR_W-1:2] == '0;
    assign en_hit  = adr_i[ADDR_W-1:2] == (ADDR_W-2)'(1);
    // a taken command write with the code lane enabled launches an operation
    assign launch  = take & we_i & cmd_hit & sel_i[3];

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    op_code_kept_a: assert property (take && we_i && cmd_hit && sel_i == 4'hf |=>
        cmd_code_o == $past(dat_i[31:24])) else $error("op code not stored");
    page_kept_a: assert property (take && we_i && cmd_hit && sel_i == 4'hf |=>
        page_addr_o == $past(dat_i[19:0])) else $error("page not stored");
    cmd_gap_a: assert property (take && !we_i && cmd_hit |=> ack_o && dat_o[23:20] == 4'h0)
        else $error("command gap bits not zero");
    cmd_readback_a: assert property (take && !we_i && cmd_hit |=>
        dat_o == {cmd_code_o, 4'h0, page_addr_o}) else $error("command read mismatch");
    enable_gap_a: assert property (take && !we_i && en_hit |=>
        (dat_o & 32'h7f01_7f01) == 32'h0) else $error("enable reserved bits set");
    irq_rise_a: assert property ($rose(irq_o) |->
        $past(ev, 1) || $past(ev, 2) || $past(wr, 1) || $past(wr, 2))
        else $error("irq rose without cause");
    irq_fall_a: assert property ($fell(irq_o) |->
        $past(wr, 1) || $past(wr, 2) || $past(rst_i, 1) || $past(rst_i, 2))
        else $error("irq fell without write");
    reset_clear_a: assert property ($fell(rst_i) |->
        cmd_code_o == 8'h00 && page_addr_o == 20'h0 && !irq_o && !ack_o)
        else $error("outputs not cleared by reset");
    start_pulse_a: assert property (cmd_start_o == $past(launch))
        else $error("launch pulse wrong");
endmodule : nvm_regs_checker

bind nvm_cmd_irq_regs nvm_regs_checker #(.ADDR_W(ADDR_W)) u_nvm_regs_checker (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o), .dat_o(dat_o),
    .evt_b0_i(evt_b0_i), .evt_b1_i(evt_b1_i), .cmd_code_o(cmd_code_o),
    .page_addr_o(page_addr_o), .cmd_start_o(cmd_start_o), .irq_o(irq_o));

`default_nettype wire

// File: verification/nvm_cmd_irq_regs_tb.sv
// self-checking bench for the flash command and irq-enable register bank
// assumes: design and checker compiled first; the bench drives every port itself
`timescale 1ns/1ns
`default_nettype none

module nvm_cmd_irq_regs_tb;
    import nvm_regs_pkg::*;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [7:0]  adr_i = 8'h00;
    logic [3:0]  sel_i = 4'h0, lanes = 4'hf;
    logic [31:0] dat_i = 32'h0, dat_o, rd, bit_m, wd, rnd = 32'hd4399123;
    evt_t        evt_b0_i = 8'h00, evt_b1_i = 8'h00;
    logic        ack_o, cmd_start_o, irq_o, busy_b0_i = 1'b0, busy_b1_i = 1'b0;
    logic [1:0]  code_b0_i = 2'b00, code_b1_i = 2'b00;
    logic [7:0]  cmd_code_o;
    logic [19:0] page_addr_o;
    int          fail_count = 0, samples_checked = 0, ticks = 0, starts = 0, starts_exp = 0;

    nvm_cmd_irq_regs #(.ADDR_W(8)) u_nvm_cmd_irq_regs (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o), .dat_o(dat_o),
        .evt_b0_i(evt_b0_i), .evt_b1_i(evt_b1_i), .busy_b0_i(busy_b0_i),
        .busy_b1_i(busy_b1_i), .code_b0_i(code_b0_i), .code_b1_i(code_b1_i),
        .cmd_code_o(cmd_code_o),
        .page_addr_o(page_addr_o), .cmd_start_o(cmd_start_o), .irq_o(irq_o));

    always #5 clk_i = ~clk_i;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // illegal-command event sits at the top of each bank half
    function automatic int slot(input int b, input int e);
        return b * 16 + (e == 7 ? 15 : e + 1);
    endfunction : slot

    // command word after a write: enabled lanes replaced, gap bits never stored
    function automatic logic [31:0] cmd_after(input logic [31:0] old, input logic [31:0] d,
                                              input logic [3:0]  be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & 32'hff0f_ffff;
        return (old & ~m) | (d & m);
    endfunction : cmd_after

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // classic cycle: held until ack is sampled, then one idle cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        sel_i <= lanes;
        dat_i <= d;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude

    // launch pulses last one cycle, so count them as they pass
    always @(posedge clk_i) begin
        if (cmd_start_o === 1'b1) starts++;
    end

    // hang guard, run needs well under a thousand cycles
    always @(posedge clk_i) begin
        ticks++;
        if (ticks == 5000) begin
            fail_count++;
            conclude();
        end
    end

    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, 8'h00, 32'h0);
        check("cmd_rst", rd, 32'h0);
        wb(1'b0, 8'h04, 32'h0);
        check("en_rst", rd, 32'h0);
        check("irq_rst", irq_o, 32'h0);
        // all-ones corner first, then random words into both registers
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            wd = (i == 0) ? 32'hffff_ffff : rnd;
            wb(1'b1, 8'h00, wd);
            starts_exp++;
            check("op", cmd_code_o, wd[31:24]);
            check("page", page_addr_o, wd[19:0]);
            wb(1'b0, 8'h00, 32'h0);
            check("cmd_rd", rd, wd & 32'hff0f_ffff);
            wb(1'b1, 8'h04, wd);
            wb(1'b0, 8'h04, 32'h0);
            check("en_rd", rd, wd & 32'h80fe_80fe);
        end
        check("starts", starts, starts_exp);
        // partial lanes: code byte kept, no launch, page lanes replaced
        rnd = lfsr(rnd);
        lanes = 4'b0111;
        wb(1'b1, 8'h00, rnd);
        lanes = 4'hf;
        wb(1'b0, 8'h00, 32'h0);
        check("cmd_lanes", rd, cmd_after(wd & 32'hff0f_ffff, rnd, 4'b0111));
        check("no_start", starts, starts_exp);
        // unmapped place: write dropped, read zero
        wb(1'b1, 8'h3c, 32'hffff_ffff);
        wb(1'b0, 8'h3c, 32'h0);
        check("unmapped", rd, 32'h0);
        // live busy and result code show through the status word, flags still clear
        rnd = lfsr(rnd);
        busy_b0_i <= rnd[0];
        busy_b1_i <= rnd[16];
        code_b0_i <= rnd[9:8];
        code_b1_i <= rnd[25:24];
        wb(1'b0, 8'h08, 32'h0);
        check("live", rd, rnd & 32'h0301_0301);
        // every event of both banks: raise under random mask, write ones to all other bits, clear
        for (int b = 0; b < 2; b++) begin
            for (int e = 0; e < 8; e++) begin
                bit_m = 32'h1 << slot(b, e);
                rnd = lfsr(rnd);
                wb(1'b1, 8'h04, rnd);
                if (b == 1) evt_b1_i <= 8'h01 << e;
                else evt_b0_i <= 8'h01 << e;
                @(posedge clk_i);
                evt_b0_i <= 8'h00;
                evt_b1_i <= 8'h00;
                repeat (2) @(posedge clk_i);
                check("irq_on", irq_o, |(rnd & bit_m));
                wb(1'b1, 8'h08, ~bit_m);
                wb(1'b0, 8'h08, 32'h0);
                check("flag", rd & 32'h80fe_80fe, bit_m);
                wb(1'b1, 8'h08, bit_m);
                check("irq_off", irq_o, 32'h0);
                wb(1'b0, 8'h08, 32'h0);
                check("cleared", rd & 32'h80fe_80fe, 32'h0);
            end
        end
        // mid-run reset with both registers loaded and a flag raised
        wb(1'b1, 8'h00, 32'hffff_ffff);
        wb(1'b1, 8'h04, 32'hffff_ffff);
        evt_b0_i <= 8'h80;
        @(posedge clk_i);
        evt_b0_i <= 8'h00;
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check("irq_mid", irq_o, 32'h0);
        wb(1'b0, 8'h00, 32'h0);
        check("cmd_mid", rd, 32'h0);
        wb(1'b0, 8'h04, 32'h0);
        check("en_mid", rd, 32'h0);
        wb(1'b0, 8'h08, 32'h0);
        check("flags_mid", rd & 32'h80fe_80fe, 32'h0);
        conclude();
    end
endmodule : nvm_cmd_irq_regs_tb

`default_nettype wire
